// ==== inc/rae_cfg.svh ====
// Constants of the event and alarm flag block: offsets, field positions,
// reset values and masks. Assumes a 32-bit APB with word-aligned offsets.
`ifndef RAE_CFG_SVH
`define RAE_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define RAE_OFF_TICK_EN     12'h014
`define RAE_OFF_CONTROL     12'h018
`define RAE_OFF_ALARM       12'h040
`define RAE_OFF_STATUS      12'h050
`define RAE_OFF_IRQ_STATUS  12'h054
`define RAE_OFF_CLEAR       12'h05c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RAE_BIT_HOUR_MASK   23
`define RAE_BIT_MIN_MASK    15
`define RAE_BIT_SEC_MASK    7
`define RAE_BIT_ALARM_ON    8
`define RAE_BIT_ALARM_IE    12
`define RAE_BIT_CALIB_IE    13
`define RAE_BIT_ALARM_F     0
`define RAE_BIT_CALIB_F     1
`define RAE_BIT_TS_F        3
`define RAE_LSB_TICK_F      16
`define RAE_NUM_TICKS       11

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define RAE_RST_WORD        32'h0000_0000
`define RAE_MASK_ALARM      32'h00bf_ffff
`define RAE_MASK_TICK_EN    32'h0000_07ff
`define RAE_MASK_CONTROL    32'h0000_3100

`endif

// ==== inc/rae_pkg.sv ====
// Types shared by the event and alarm flag block.
// Assumes rae_cfg.svh holds all numeric constants.
package rae_pkg;

   // ------------------------------------------------------------
   // Current calendar time, BCD, as the counter delivers it
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] hour_tens;     // Hour tens digit
      logic [3:0] hour_units;    // Hour units digit
      logic [2:0] minute_tens;   // Minute tens digit
      logic [3:0] minute_units;  // Minute units digit
      logic [2:0] second_tens;   // Second tens digit
      logic [3:0] second_units;  // Second units digit
   } rae_time_t;

   // ------------------------------------------------------------
   // One-cycle event pulses from the kernel logic
   // ------------------------------------------------------------
   typedef struct packed {
      logic [10:0] tick;         // 1024 Hz at bit 10 ... day at bit 0
      logic        timestamp;    // Timestamp captured
      logic        calib_end;    // Smooth-calibration cycle ended
   } rae_events_t;

   // APB access phases seen by the slave
   typedef enum logic [1:0] {
      RAE_IDLE,
      RAE_SETUP,
      RAE_ACCESS
   } rae_phase_t;

endpackage

// ==== rtl/rae_alarm_cmp.sv ====
// Alarm comparator: masked BCD compare of alarm setting against time.
// Assumes time and setting are stable in the I_CLK domain.
`timescale 1ns/1ps
`include "rae_cfg.svh"

module rae_alarm_cmp (
   // Setting and time
   input  wire logic [31:0]         i_alarm,
   input  wire rae_pkg::rae_time_t  i_time,
   // Result
   output logic                     o_match
);

   // ------------------------------------------------------------
   // Field compares
   // ------------------------------------------------------------
   logic hour_ok;   // Hours agree or are masked
   logic min_ok;    // Minutes agree or are masked
   logic sec_ok;    // Seconds agree or are masked

   always_comb begin
      // Hours: tens 21:20, units 19:16; bit 22 never compared
      hour_ok = i_alarm[`RAE_BIT_HOUR_MASK] ||
                (i_alarm[21:16] == {i_time.hour_tens, i_time.hour_units});
      // Minutes: tens 14:12, units 11:8
      min_ok  = i_alarm[`RAE_BIT_MIN_MASK] ||
                (i_alarm[14:8] == {i_time.minute_tens, i_time.minute_units});
      // Seconds: tens 6:4, units 3:0
      sec_ok  = i_alarm[`RAE_BIT_SEC_MASK] ||
                (i_alarm[6:0] == {i_time.second_tens, i_time.second_units});
      o_match = hour_ok && min_ok && sec_ok;
   end

endmodule

// ==== rtl/rae_top.sv ====
// Event and alarm flag block of the real-time clock, with APB registers.
// Assumes I_CLK is the kernel clock, I_RESETN the always-on reset, and
// that time and event inputs come from logic on the same clock.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "rae_cfg.svh"

module rae_top (
   // Clock and always-on reset
   input  wire logic                    I_CLK,
   input  wire logic                    I_RESETN,
   // APB slave
   input  wire logic                    I_PSEL,
   input  wire logic                    I_PENABLE,
   input  wire logic                    I_PWRITE,
   input  wire logic [11:0]             I_PADDR,
   input  wire logic [31:0]             I_PWDATA,
   output logic [31:0]                  O_PRDATA,
   output logic                         O_PREADY,
   output logic                         O_PSLVERR,
   // Kernel side
   input  wire rae_pkg::rae_time_t      I_TIME,
   input  wire rae_pkg::rae_events_t    I_EVENTS,
   // Interrupt request
   output logic                         O_IRQ
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // Address hit on a register word, low two bits ignored
   function automatic logic addr_hit(input logic [11:0] a,
                                     input logic [11:0] off);
      addr_hit = (a[11:2] == off[11:2]);
   endfunction

   // Sticky flag update: set wins over a clear in the same cycle
   function automatic logic [31:0] sticky(input logic [31:0] cur,
                                          input logic [31:0] set,
                                          input logic [31:0] clr);
      sticky = (cur & ~clr) | set;
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   rae_pkg::rae_phase_t phase_q;        // APB phase tracker
   rae_pkg::rae_phase_t phase_d;
   logic [31:0]         alarm_q;        // Alarm setting
   logic [31:0]         alarm_d;
   logic [31:0]         tick_en_q;      // Per-tick irq enables
   logic [31:0]         tick_en_d;
   logic [31:0]         control_q;      // Alarm on and irq enables
   logic [31:0]         control_d;
   logic [31:0]         status_q;       // Event status flags
   logic [31:0]         status_d;
   logic [31:0]         irq_stat_q;     // Interrupt status flags
   logic [31:0]         irq_stat_d;
   logic                match_q;        // Armed comparator result last cycle
   logic                match_d;
   logic [31:0]         rdata_q;        // Read data register
   logic [31:0]         rdata_d;
   logic                err_q;          // Unmapped address seen in setup
   logic                err_d;

   logic                setup;          // APB setup cycle
   logic                wr_take;        // Write takes effect this edge
   logic                mapped;         // Address decodes to a register
   logic                cmp_match;      // Masked compare result
   logic                alarm_evt;      // Rising edge of a match
   logic [31:0]         clr_vec;        // Bits cleared by software
   logic [31:0]         stat_set;       // Status bits set by events
   logic [31:0]         irq_set;        // Irq bits set by events
   logic [31:0]         src_vec;        // All event sources in place

   // ------------------------------------------------------------
   // Alarm comparator
   // ------------------------------------------------------------
   rae_alarm_cmp u_cmp (
      .i_alarm (alarm_q),
      .i_time  (I_TIME),
      .o_match (cmp_match)
   );

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------

   // Setup and access qualifiers and address map
   always_comb begin
      setup   = I_PSEL && !I_PENABLE;
      // Only an access that follows a tracked setup may write
      wr_take = I_PSEL && I_PENABLE && I_PWRITE && (phase_q == rae_pkg::RAE_SETUP);
      mapped  = addr_hit(I_PADDR, `RAE_OFF_TICK_EN)
             || addr_hit(I_PADDR, `RAE_OFF_CONTROL)
             || addr_hit(I_PADDR, `RAE_OFF_ALARM)
             || addr_hit(I_PADDR, `RAE_OFF_STATUS)
             || addr_hit(I_PADDR, `RAE_OFF_IRQ_STATUS)
             || addr_hit(I_PADDR, `RAE_OFF_CLEAR);
   end

   // Zero wait state: data was prepared in the setup cycle
   always_comb begin
      O_PREADY  = I_PSEL && I_PENABLE;
      O_PSLVERR = I_PSEL && I_PENABLE && err_q;
      O_PRDATA  = rdata_q;
   end

   // ------------------------------------------------------------
   // Bus phase and read data, next values
   // ------------------------------------------------------------
   always_comb begin
      phase_d = phase_q;
      rdata_d = rdata_q;
      err_d   = err_q;
      case (phase_q)
         rae_pkg::RAE_IDLE: begin
            if (setup) begin
               phase_d = rae_pkg::RAE_SETUP;
            end
         end
         rae_pkg::RAE_SETUP: begin
            phase_d = rae_pkg::RAE_ACCESS;
         end
         rae_pkg::RAE_ACCESS: begin
            // Back-to-back setup may follow at once
            phase_d = setup ? rae_pkg::RAE_SETUP : rae_pkg::RAE_IDLE;
         end
         default: begin
            phase_d = rae_pkg::RAE_IDLE;
         end
      endcase
      // Capture read word in the setup cycle
      if (setup) begin
         err_d   = !mapped;
         rdata_d = `RAE_RST_WORD;
         if (!I_PWRITE) begin
            if (addr_hit(I_PADDR, `RAE_OFF_TICK_EN)) begin
               rdata_d = tick_en_q;
            end else if (addr_hit(I_PADDR, `RAE_OFF_CONTROL)) begin
               rdata_d = control_q;
            end else if (addr_hit(I_PADDR, `RAE_OFF_ALARM)) begin
               rdata_d = alarm_q;
            end else if (addr_hit(I_PADDR, `RAE_OFF_STATUS)) begin
               rdata_d = status_q;
            end else if (addr_hit(I_PADDR, `RAE_OFF_IRQ_STATUS)) begin
               rdata_d = irq_stat_q;
            end else begin
               // Clear register and holes read zero
               rdata_d = `RAE_RST_WORD;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Configuration registers, next values
   // ------------------------------------------------------------
   always_comb begin
      alarm_d   = alarm_q;
      tick_en_d = tick_en_q;
      control_d = control_q;
      if (wr_take) begin
         if (addr_hit(I_PADDR, `RAE_OFF_ALARM)) begin
            // Setting frozen while the alarm is armed
            if (!control_q[`RAE_BIT_ALARM_ON]) begin
               alarm_d = I_PWDATA & `RAE_MASK_ALARM;
            end
         end else if (addr_hit(I_PADDR, `RAE_OFF_TICK_EN)) begin
            tick_en_d = I_PWDATA & `RAE_MASK_TICK_EN;
         end else if (addr_hit(I_PADDR, `RAE_OFF_CONTROL)) begin
            control_d = I_PWDATA & `RAE_MASK_CONTROL;
         end else begin
            // Status registers are read-only; writes dropped
            alarm_d = alarm_q;
         end
      end
   end

   // ------------------------------------------------------------
   // Event flags, next values
   // ------------------------------------------------------------
   always_comb begin
      // Only an armed alarm reports, and only on the first
      // matching cycle, so a cleared flag does not reappear
      // for the rest of the matching second
      match_d   = cmp_match && control_q[`RAE_BIT_ALARM_ON];
      alarm_evt = match_d && !match_q;

      // Place every source at its flag position
      src_vec = `RAE_RST_WORD;
      src_vec[`RAE_LSB_TICK_F +: `RAE_NUM_TICKS] = I_EVENTS.tick;
      src_vec[`RAE_BIT_TS_F]    = I_EVENTS.timestamp;
      src_vec[`RAE_BIT_CALIB_F] = I_EVENTS.calib_end;
      src_vec[`RAE_BIT_ALARM_F] = alarm_evt;
      stat_set = src_vec;

      // Interrupt flags only where the source is enabled
      irq_set = `RAE_RST_WORD;
      irq_set[`RAE_LSB_TICK_F +: `RAE_NUM_TICKS] =
         I_EVENTS.tick & tick_en_q[`RAE_NUM_TICKS-1:0];
      irq_set[`RAE_BIT_CALIB_F] =
         I_EVENTS.calib_end && control_q[`RAE_BIT_CALIB_IE];
      irq_set[`RAE_BIT_ALARM_F] =
         alarm_evt && control_q[`RAE_BIT_ALARM_IE];

      // Write-1-to-clear; zeros leave flags alone
      clr_vec = `RAE_RST_WORD;
      if (wr_take && addr_hit(I_PADDR, `RAE_OFF_CLEAR)) begin
         clr_vec[`RAE_LSB_TICK_F +: `RAE_NUM_TICKS] =
            I_PWDATA[`RAE_LSB_TICK_F +: `RAE_NUM_TICKS];
         clr_vec[`RAE_BIT_TS_F]    = I_PWDATA[`RAE_BIT_TS_F];
         clr_vec[`RAE_BIT_CALIB_F] = I_PWDATA[`RAE_BIT_CALIB_F];
         clr_vec[`RAE_BIT_ALARM_F] = I_PWDATA[`RAE_BIT_ALARM_F];
      end

      // One clear vector serves both registers, so a pair always
      // clears together; a new event in the same cycle wins
      status_d   = sticky(status_q, stat_set, clr_vec);
      irq_stat_d = sticky(irq_stat_q, irq_set, clr_vec);
   end

   // Request stays high while any interrupt flag is set
   always_comb begin
      O_IRQ = |irq_stat_q;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------

   // Bus state; same always-on reset as the rest
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         phase_q <= rae_pkg::RAE_IDLE;
         rdata_q <= `RAE_RST_WORD;
         err_q   <= 1'b0;
      end else begin
         phase_q <= phase_d;
         rdata_q <= rdata_d;
         err_q   <= err_d;
      end
   end

   // Configuration state
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         alarm_q   <= `RAE_RST_WORD;
         tick_en_q <= `RAE_RST_WORD;
         control_q <= `RAE_RST_WORD;
      end else begin
         alarm_q   <= alarm_d;
         tick_en_q <= tick_en_d;
         control_q <= control_d;
      end
   end

   // Flags: the always-on reset or a write-1-to-clear returns them to zero
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         status_q   <= `RAE_RST_WORD;
         irq_stat_q <= `RAE_RST_WORD;
         match_q    <= 1'b0;
      end else begin
         status_q   <= status_d;
         irq_stat_q <= irq_stat_d;
         match_q    <= match_d;
      end
   end

endmodule

// ==== test/rae_top_monitor.sv ====
// Checker of the event and alarm flag block, bound into rae_top.
// Assumes only the top ports are visible; APB answers with no wait state.
`timescale 1ns/1ps
`include "rae_cfg.svh"

module rae_top_monitor (
   // Clock and always-on reset
   input  wire logic                 I_CLK,
   input  wire logic                 I_RESETN,
   // APB slave side
   input  wire logic                 I_PSEL,
   input  wire logic                 I_PENABLE,
   input  wire logic                 I_PWRITE,
   input  wire logic [11:0]          I_PADDR,
   input  wire logic [31:0]          I_PWDATA,
   input  wire logic [31:0]          O_PRDATA,
   input  wire logic                 O_PREADY,
   input  wire logic                 O_PSLVERR,
   // Kernel side and request
   input  wire rae_pkg::rae_time_t   I_TIME,
   input  wire rae_pkg::rae_events_t I_EVENTS,
   input  wire logic                 O_IRQ
);
   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   logic [11:0] word_a;  // Word address, low bits dropped
   logic        acc;     // Access phase of a transfer
   logic        mapped;  // Address hits a register
   logic        clr_wr;  // Access that writes the clear register
   assign word_a = I_PADDR & 12'hffc;
   assign acc    = I_PSEL & I_PENABLE;
   assign clr_wr = acc & I_PWRITE & (word_a == `RAE_OFF_CLEAR);
   assign mapped = (word_a == `RAE_OFF_TICK_EN) | (word_a == `RAE_OFF_CONTROL) |
                   (word_a == `RAE_OFF_ALARM) | (word_a == `RAE_OFF_STATUS) |
                   (word_a == `RAE_OFF_IRQ_STATUS) | (word_a == `RAE_OFF_CLEAR);

   // One domain only, so clock and reset are given once
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);

   // ------------------------------------------------------------
   // Bus answers
   // ------------------------------------------------------------
   chk_ready_phase:
      assert property (O_PREADY == acc) else $error("Ready does not follow access");
   chk_err_unmapped:
      assert property (acc && !mapped |-> O_PSLVERR) else $error("No error on hole");
   chk_err_mapped:
      assert property (!(acc && !mapped) |-> !O_PSLVERR) else $error("Stray slave error");
   chk_clear_reads_zero:
      assert property (acc && !I_PWRITE && word_a == `RAE_OFF_CLEAR |-> O_PRDATA == 32'h0)
         else $error("Clear register read not zero");
   chk_hole_reads_zero:
      assert property (acc && !I_PWRITE && !mapped |-> O_PRDATA == 32'h0)
         else $error("Unmapped read not zero");
   // Read data may move only after a setup edge
   chk_prdata_hold:
      assert property (!$past(I_PSEL && !I_PENABLE) |-> $stable(O_PRDATA))
         else $error("Read data moved outside setup");

   // ------------------------------------------------------------
   // Interrupt request
   // ------------------------------------------------------------
   // A rise needs a tick, a calibration end, a time change or a bus transfer;
   // timestamp alone must never raise it
   chk_irq_rise_cause:
      assert property ($rose(O_IRQ) |-> $past(I_EVENTS.tick != 11'h0 || I_EVENTS.calib_end)
                       || $past(I_PSEL, 2) || ($past(I_TIME, 1) != $past(I_TIME, 2)))
         else $error("Interrupt rose without a cause");
   chk_irq_sticky:
      assert property (O_IRQ && !clr_wr |=> O_IRQ) else $error("Interrupt dropped by itself");
endmodule

bind rae_top rae_top_monitor u_mon (
   .I_CLK     (I_CLK),
   .I_RESETN  (I_RESETN),
   .I_PSEL    (I_PSEL),
   .I_PENABLE (I_PENABLE),
   .I_PWRITE  (I_PWRITE),
   .I_PADDR   (I_PADDR),
   .I_PWDATA  (I_PWDATA),
   .O_PRDATA  (O_PRDATA),
   .O_PREADY  (O_PREADY),
   .O_PSLVERR (O_PSLVERR),
   .I_TIME    (I_TIME),
   .I_EVENTS  (I_EVENTS),
   .O_IRQ     (O_IRQ)
);

// ==== test/test_rae_top.sv ====
// Self-checking bench of the event and alarm flag block over APB.
// Assumes a zero-wait APB slave and one-cycle event pulses on I_CLK.
`timescale 1ns/1ps
`include "rae_cfg.svh"

module test_rae_top;
   // ------------------------------------------------------------
   // Stimulus and observation
   // ------------------------------------------------------------
   logic                clk, rst_n, psel, penable, pwrite, irq, pready, pslverr;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, q, s, m;
   logic                e;
   rae_pkg::rae_time_t  tim;   // Calendar time driven in
   rae_pkg::rae_events_t ev;   // Event pulses driven in
   int                  err_total, n_tests, i;
   // Alarm cases: setting, time in the same layout, expected hit
   logic [31:0] al [7] = '{32'h0012_3456, 32'h0012_3456, 32'h0092_3456, 32'h0012_3456,
                           32'h0012_b456, 32'h0012_3456, 32'h0012_34d6};
   logic [31:0] tw [7] = '{32'h0012_3456, 32'h0013_3456, 32'h0013_3456, 32'h0012_3556,
                           32'h0012_3556, 32'h0012_3457, 32'h0012_3457};
   logic [6:0]  hit    = 7'b1010101;

   rae_top dut (.I_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
                .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
                .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TIME(tim), .I_EVENTS(ev),
                .O_IRQ(irq));

   always #4 clk = ~clk;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic end_sim;
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One transfer; request held until ready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the watchdog ends a wait for ready
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // Read and compare; mapped reads must not raise an error
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
      chk({31'h0, e}, 32'h0);
   endtask

   task automatic pulse(input logic [12:0] p);
      @(posedge clk);
      ev <= p;
      @(posedge clk);
      ev <= '0;
   endtask

   function automatic rae_pkg::rae_time_t to_time(input logic [31:0] a);
      return {a[21:20], a[19:16], a[14:12], a[11:8], a[6:4], a[3:0]};
   endfunction

   // ------------------------------------------------------------
   // Watchdog: the whole sequence takes well under 3000 cycles
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      tim = '0;
      ev = '0;
      err_total = 0;
      n_tests = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rdc(`RAE_OFF_STATUS, 32'h0);
      rdc(`RAE_OFF_IRQ_STATUS, 32'h0);
      rdc(`RAE_OFF_CLEAR, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      wr(`RAE_OFF_ALARM, 32'hffff_ffff);
      rdc(`RAE_OFF_ALARM, `RAE_MASK_ALARM);
      // Every event at once, every other tick interrupt enabled (six of eleven)
      wr(`RAE_OFF_TICK_EN, 32'h0000_0555);
      rdc(`RAE_OFF_TICK_EN, 32'h0000_0555);
      pulse(13'h1fff);
      rdc(`RAE_OFF_STATUS, 32'h07ff_000a);
      rdc(`RAE_OFF_IRQ_STATUS, 32'h0555_0000);
      chk({31'h0, irq}, 32'h1);
      // Clear register still reads zero while flags stand
      rdc(`RAE_OFF_CLEAR, 32'h0);
      // Writes of zero and writes to read-only places change nothing
      wr(`RAE_OFF_STATUS, 32'hffff_ffff);
      wr(`RAE_OFF_IRQ_STATUS, 32'hffff_ffff);
      wr(`RAE_OFF_CLEAR, 32'h0);
      rdc(`RAE_OFF_STATUS, 32'h07ff_000a);
      rdc(`RAE_OFF_IRQ_STATUS, 32'h0555_0000);
      s = 32'h07ff_000a;
      m = 32'h0555_0000;
      for (i = 0; i < 11; i++) begin
         wr(`RAE_OFF_CLEAR, 32'h1 << (16 + i));
         s[16 + i] = 1'b0;
         m[16 + i] = 1'b0;
         rdc(`RAE_OFF_STATUS, s);
         rdc(`RAE_OFF_IRQ_STATUS, m);
      end
      chk({31'h0, irq}, 32'h0);
      wr(`RAE_OFF_CLEAR, 32'h8);
      rdc(`RAE_OFF_STATUS, 32'h2);
      wr(`RAE_OFF_CLEAR, 32'h2);
      rdc(`RAE_OFF_STATUS, 32'h0);
      // Calibration interrupt with its enable set
      wr(`RAE_OFF_CONTROL, 32'h0000_2000);
      rdc(`RAE_OFF_CONTROL, 32'h0000_2000);
      pulse(13'h0001);
      rdc(`RAE_OFF_IRQ_STATUS, 32'h2);
      wr(`RAE_OFF_CLEAR, 32'h2);
      rdc(`RAE_OFF_IRQ_STATUS, 32'h0);
      // Alarm cases: exact match, then each field differing, masked or not
      for (i = 0; i < 7; i++) begin
         wr(`RAE_OFF_CONTROL, 32'h0);
         tim <= '0;
         wr(`RAE_OFF_ALARM, al[i]);
         wr(`RAE_OFF_CONTROL, 32'h0000_1100);
         @(posedge clk);
         tim <= to_time(tw[i]);
         repeat (3) @(posedge clk);
         rdc(`RAE_OFF_STATUS, {31'h0, hit[i]});
         rdc(`RAE_OFF_IRQ_STATUS, {31'h0, hit[i]});
         wr(`RAE_OFF_ALARM, 32'h0);
         rdc(`RAE_OFF_ALARM, al[i]);
         wr(`RAE_OFF_CLEAR, 32'h1);
         rdc(`RAE_OFF_IRQ_STATUS, 32'h0);
      end
      // Armed alarm without its interrupt enable: status flag only
      wr(`RAE_OFF_CONTROL, 32'h0);
      tim <= '0;
      wr(`RAE_OFF_CONTROL, 32'h0000_0100);
      tim <= to_time(tw[0]);
      repeat (3) @(posedge clk);
      rdc(`RAE_OFF_STATUS, 32'h1);
      rdc(`RAE_OFF_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      end_sim;
   end
endmodule
